//--- eag_guard.sv
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module eag_guard
(
   // clock and reset
   input  wire logic                       i_mclk,
   input  wire logic                       i_rst,
   // apb slave
   input  wire logic                       i_psel,
   input  wire logic                       i_penable,
   input  wire logic                       i_pwrite,
   input  wire logic [7:0]                 i_paddr,
   input  wire logic [31:0]                i_pwdata,
   input  wire logic [3:0]                 i_pstrb,
   output logic                            o_pready,
   output logic                            o_pslverr,
   output logic [31:0]                     o_prdata,
   // chip mode pins, asynchronous
   input  wire logic                       i_rom_disabled,
   input  wire logic                       i_hw_standby,
   // sequencer command view
   input  wire logic                       i_cmd_valid,
   input  wire logic                       i_cmd_read,
   input  wire logic                       i_cmd_write,
   input  wire logic                       i_cmd_pe,
   input  wire logic [eag_pkg::BLK_W-1:0]  i_cmd_block,
   input  wire logic                       i_pe_normal_mode,
   input  wire logic                       i_data_pe_entry,
   input  wire logic [6:0]                 i_code_pe_entry,
   input  wire logic                       i_code_flash_access_err,
   input  wire logic                       i_seq_error,
   input  wire logic                       i_seq_clear_done,
   // cpu access view
   input  wire logic                       i_fetch_valid,
   input  wire logic                       i_cpu_rd_valid,
   input  wire logic [eag_pkg::BLK_W-1:0]  i_cpu_rd_block,
   // outputs to sequencer, cpu path and interrupt controller
   output logic                            o_cmd_lock,
   output logic                            o_illegal_cmd_err,
   output logic [eag_pkg::NUM_BLOCKS-1:0]  o_block_read_en,
   output logic [eag_pkg::NUM_BLOCKS-1:0]  o_block_pe_en,
   output logic                            o_flash_error_irq
);

   // mode pin synchronisers
   logic rom_dis_m_r;
   logic rom_dis_r;
   logic stby_m_r;
   logic stby_r;

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         rom_dis_m_r <= 1'b0;
         rom_dis_r   <= 1'b0;
         stby_m_r    <= 1'b0;
         stby_r      <= 1'b0;
      end
      else
      begin
         rom_dis_m_r <= i_rom_disabled;
         rom_dis_r   <= rom_dis_m_r;
         stby_m_r    <= i_hw_standby;
         stby_r      <= stby_m_r;
      end
   end

   // register state
   logic [7:0]  flag_r;
   logic [7:0]  flag_nxt;
   logic [7:0]  seen_r;
   logic [7:0]  seen_nxt;
   logic        lock_r;
   logic        lock_nxt;
   logic [7:0]  ie_r;
   logic [7:0]  ie_nxt;
   logic [15:0] rd_en_r;
   logic [15:0] rd_en_nxt;
   logic [15:0] pe_en_r;
   logic [15:0] pe_en_nxt;
   logic        ill_r;
   logic        ill_nxt;
   logic        irq_r;
   logic        irq_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   // bus decode
   logic        setup;
   logic        access;
   logic        wr;
   logic        rd_status;
   logic        word_wr;
   logic        mapped;
   logic [7:0]  status_view;
   logic [7:0]  ev;
   logic [7:0]  clr;

   assign setup   = i_psel && !i_penable;
   assign access  = i_psel && i_penable;
   // writes are ignored while the on-chip rom is disabled
   assign wr      = access && i_pwrite && !rom_dis_r;
   // a key needs both low lanes; a lone byte never unlocks
   assign word_wr = (i_pstrb[1:0] == 2'b11);
   assign mapped  = (i_paddr == eag_pkg::OFS_STATUS)   || (i_paddr == eag_pkg::OFS_IRQ_EN)
                 || (i_paddr == eag_pkg::OFS_RD_EN_LO) || (i_paddr == eag_pkg::OFS_RD_EN_HI)
                 || (i_paddr == eag_pkg::OFS_PE_EN_LO) || (i_paddr == eag_pkg::OFS_PE_EN_HI);
   assign rd_status = access && !i_pwrite && !rom_dis_r && (i_paddr == eag_pkg::OFS_STATUS);

   // status as software sees it; reserved bits stay zero
   always_comb
   begin
      status_view                    = flag_r & eag_pkg::ERR_FLAG_MASK;
      status_view[eag_pkg::BIT_LOCK] = lock_r;
   end

   // error events, one per error flag bit
   always_comb
   begin
      ev = 8'h00;
      ev[eag_pkg::BIT_CODE_ERR] = i_code_flash_access_err;
      ev[eag_pkg::BIT_ACCESS]   = i_cmd_valid &&
                                  ((i_cmd_read && i_data_pe_entry && i_pe_normal_mode)
                                   || (i_cmd_write && !i_data_pe_entry)
                                   || (|i_code_pe_entry));
      ev[eag_pkg::BIT_FETCH]    = i_fetch_valid;
      ev[eag_pkg::BIT_RD_PROT]  = i_cpu_rd_valid && !rd_en_r[i_cpu_rd_block];
      ev[eag_pkg::BIT_WR_PROT]  = i_cmd_valid && i_cmd_pe && !pe_en_r[i_cmd_block];
   end

   // per-flag sticky logic: set beats a same-cycle clear
   genvar b;
   generate
      for (b = 0; b < 8; b++)
      begin : g_flag
         if (eag_pkg::ERR_FLAG_MASK[b])
         begin : g_live
            // clear only on a written 0 after the flag was read as 1
            assign clr[b]      = wr && i_pstrb[0] && (i_paddr == eag_pkg::OFS_STATUS)
                                 && !i_pwdata[b] && seen_r[b];
            assign flag_nxt[b] = stby_r ? 1'b0 : (ev[b] || (flag_r[b] && !clr[b]));
            // record what the read really returned; a flag set after setup was not seen
            assign seen_nxt[b] = stby_r ? 1'b0
                               : ((seen_r[b] || (rd_status && prdata_r[b])) && flag_nxt[b]);
         end
         else
         begin : g_rsvd
            assign clr[b]      = 1'b0;
            assign flag_nxt[b] = 1'b0;
            assign seen_nxt[b] = 1'b0;
         end
      end
   endgenerate

   // lock, illegal-command pulse and interrupt
   always_comb
   begin
      // the lock stays until the sequencer finishes a status-clear,
      // so clearing the flags alone (writing 0x10) is not enough
      lock_nxt = lock_r;
      if (i_seq_clear_done)
         lock_nxt = 1'b0;
      if (i_seq_error || (|(flag_nxt & eag_pkg::ERR_FLAG_MASK)))
         lock_nxt = 1'b1;
      if (stby_r)
         lock_nxt = 1'b0;
      ill_nxt  = ev[eag_pkg::BIT_ACCESS] && !stby_r;
      irq_nxt  = |(status_view & ie_r & eag_pkg::IE_DEF_MASK);
   end

   // software-written registers
   always_comb
   begin
      ie_nxt    = ie_r;
      rd_en_nxt = rd_en_r;
      pe_en_nxt = pe_en_r;
      if (wr && (i_paddr == eag_pkg::OFS_IRQ_EN) && i_pstrb[0])
         ie_nxt = i_pwdata[7:0] & eag_pkg::IE_DEF_MASK;
      // key byte only gates the write and is never stored
      if (wr && word_wr && (i_paddr == eag_pkg::OFS_RD_EN_LO) && (i_pwdata[15:8] == eag_pkg::KEY_RD_LO))
         rd_en_nxt[7:0] = i_pwdata[7:0];
      if (wr && word_wr && (i_paddr == eag_pkg::OFS_RD_EN_HI) && (i_pwdata[15:8] == eag_pkg::KEY_RD_HI))
         rd_en_nxt[15:8] = i_pwdata[7:0];
      if (wr && word_wr && (i_paddr == eag_pkg::OFS_PE_EN_LO) && (i_pwdata[15:8] == eag_pkg::KEY_PE_LO))
         pe_en_nxt[7:0] = i_pwdata[7:0];
      if (wr && word_wr && (i_paddr == eag_pkg::OFS_PE_EN_HI) && (i_pwdata[15:8] == eag_pkg::KEY_PE_HI))
         pe_en_nxt[15:8] = i_pwdata[7:0];
      if (stby_r)
      begin
         ie_nxt    = eag_pkg::IRQ_EN_RST;
         rd_en_nxt = {eag_pkg::BLK_EN_RST, eag_pkg::BLK_EN_RST};
         pe_en_nxt = {eag_pkg::BLK_EN_RST, eag_pkg::BLK_EN_RST};
      end
   end

   // read data captured in the setup cycle so it comes from a flop
   always_comb
   begin
      prdata_nxt = prdata_r;
      if (setup)
      begin
         prdata_nxt = 32'h0000_0000;
         if (!rom_dis_r)
         begin
            unique case (i_paddr)
               eag_pkg::OFS_STATUS   : prdata_nxt[7:0] = status_view;
               eag_pkg::OFS_IRQ_EN   : prdata_nxt[7:0] = ie_r;
               eag_pkg::OFS_RD_EN_LO : prdata_nxt[7:0] = rd_en_r[7:0];
               eag_pkg::OFS_RD_EN_HI : prdata_nxt[7:0] = rd_en_r[15:8];
               eag_pkg::OFS_PE_EN_LO : prdata_nxt[7:0] = pe_en_r[7:0];
               eag_pkg::OFS_PE_EN_HI : prdata_nxt[7:0] = pe_en_r[15:8];
               default               : prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // register everything
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         flag_r   <= eag_pkg::STATUS_RST;
         seen_r   <= 8'h00;
         lock_r   <= 1'b0;
         ie_r     <= eag_pkg::IRQ_EN_RST;
         rd_en_r  <= 16'h0000;
         pe_en_r  <= 16'h0000;
         ill_r    <= 1'b0;
         irq_r    <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         flag_r   <= flag_nxt;
         seen_r   <= seen_nxt;
         lock_r   <= lock_nxt;
         ie_r     <= ie_nxt;
         rd_en_r  <= rd_en_nxt;
         pe_en_r  <= pe_en_nxt;
         ill_r    <= ill_nxt;
         irq_r    <= irq_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // outputs; zero-wait slave
   assign o_pready          = 1'b1;
   assign o_pslverr         = access && !mapped;
   assign o_prdata          = prdata_r;
   assign o_cmd_lock        = lock_r;
   assign o_illegal_cmd_err = ill_r;
   assign o_block_read_en   = rd_en_r;
   assign o_block_pe_en     = pe_en_r;
   assign o_flash_error_irq = irq_r;

   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   a_flag_locks: assert property (|(flag_r & eag_pkg::ERR_FLAG_MASK) |-> lock_r)
      else $error("flag set without command lock");
   a_rom_dis_zero: assert property (setup && rom_dis_r |=> o_prdata == 32'h0000_0000)
      else $error("register readable while rom disabled");
   a_clear_after_read: assert property (
      $fell(flag_r[eag_pkg::BIT_ACCESS]) && !$past(stby_r) |-> $past(seen_r[eag_pkg::BIT_ACCESS]))
      else $error("flag cleared without prior read");
   a_lock_release: assert property (lock_r && i_seq_clear_done && !i_seq_error && !(|flag_nxt) |=> !lock_r)
      else $error("lock not released by status clear");
   a_access_write: assert property (
      i_cmd_valid && i_cmd_write && !i_data_pe_entry && !stby_r
      |=> flag_r[eag_pkg::BIT_ACCESS] ##0 o_illegal_cmd_err)
      else $error("access error not raised");
   a_illegal_once: assert property (o_illegal_cmd_err |-> $past(i_cmd_valid))
      else $error("illegal command pulse without command");
   a_fetch_err: assert property (i_fetch_valid && !stby_r |=> flag_r[eag_pkg::BIT_FETCH])
      else $error("fetch error not raised");
   a_read_prot: assert property (
      i_cpu_rd_valid && !rd_en_r[i_cpu_rd_block] && !stby_r |=> flag_r[eag_pkg::BIT_RD_PROT] && lock_r)
      else $error("read protect error not raised");
   a_pe_prot: assert property (
      i_cmd_valid && i_cmd_pe && !pe_en_r[i_cmd_block] && !stby_r |=> flag_r[eag_pkg::BIT_WR_PROT])
      else $error("program/erase protect error not raised");
   a_irq_gate: assert property (o_flash_error_irq |-> $past(|(status_view & ie_r)))
      else $error("interrupt without enabled flag");
   a_key_guard: assert property (
      wr && (i_paddr == eag_pkg::OFS_RD_EN_LO) && (!word_wr || i_pwdata[15:8] != eag_pkg::KEY_RD_LO) && !stby_r
      |=> $stable(rd_en_r[7:0]))
      else $error("read enable changed without key");

   // keyed and masked register updates
   a_lo_key: assert property (
      wr && word_wr && (i_paddr == eag_pkg::OFS_RD_EN_LO) && (i_pwdata[15:8] == eag_pkg::KEY_RD_LO) && !stby_r
      |=> rd_en_r[7:0] == $past(i_pwdata[7:0]))
      else $error("read enable low not loaded with key");

   a_hi_key: assert property (
      wr && word_wr && (i_paddr == eag_pkg::OFS_RD_EN_HI) && (i_pwdata[15:8] == eag_pkg::KEY_RD_HI) && !stby_r
      |=> rd_en_r[15:8] == $past(i_pwdata[7:0]))
      else $error("read enable high not loaded with key");

   a_pe_key: assert property (
      wr && word_wr && (i_paddr == eag_pkg::OFS_PE_EN_LO) && (i_pwdata[15:8] == eag_pkg::KEY_PE_LO) && !stby_r
      |=> pe_en_r[7:0] == $past(i_pwdata[7:0]))
      else $error("program/erase enable low not loaded with key");

   a_irq_mask: assert property (ie_r == 8'h00 |=> !o_flash_error_irq)
      else $error("interrupt with all enables off");

   a_lock_holds: assert property (lock_r && !i_seq_clear_done && !stby_r |=> lock_r)
      else $error("lock dropped without status clear");

   a_one_keeps: assert property (
      wr && i_pstrb[0] && (i_paddr == eag_pkg::OFS_STATUS) && i_pwdata[eag_pkg::BIT_RD_PROT]
      && flag_r[eag_pkg::BIT_RD_PROT] && !stby_r |=> flag_r[eag_pkg::BIT_RD_PROT])
      else $error("writing one cleared a flag");

   a_rom_dis_wr: assert property (
      access && i_pwrite && rom_dis_r && !stby_r
      |=> $stable(ie_r) && $stable(rd_en_r) && $stable(pe_en_r))
      else $error("register written while rom disabled");

   a_stby_init: assert property (
      stby_r |=> (flag_r == eag_pkg::STATUS_RST) && (ie_r == eag_pkg::IRQ_EN_RST) && (rd_en_r == 16'h0000) && !lock_r)
      else $error("standby did not initialise registers");

   a_rsvd_zero: assert property (
      setup && ((i_paddr == eag_pkg::OFS_STATUS) || (i_paddr == eag_pkg::OFS_IRQ_EN)) |=> o_prdata[6:5] == 2'h0)
      else $error("reserved bits read as one");

endmodule

`default_nettype wire

//--- eag_pkg.sv
`default_nettype none
package eag_pkg;

   // register byte addresses on the 32-bit bus
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h04;
   localparam logic [7:0] OFS_RD_EN_LO = 8'h08;
   localparam logic [7:0] OFS_RD_EN_HI = 8'h0c;
   localparam logic [7:0] OFS_PE_EN_LO = 8'h10;
   localparam logic [7:0] OFS_PE_EN_HI = 8'h14;

   // status and enable bit positions
   localparam int BIT_CODE_ERR  = 7;
   localparam int BIT_LOCK      = 4;
   localparam int BIT_ACCESS    = 3;
   localparam int BIT_FETCH     = 2;
   localparam int BIT_RD_PROT   = 1;
   localparam int BIT_WR_PROT   = 0;

   // error flags that software clears; bit 4 is read-only, 6 and 5 reserved
   localparam logic [7:0] ERR_FLAG_MASK = 8'h8f;
   // defined enable bits of the irq enable register
   localparam logic [7:0] IE_DEF_MASK   = 8'h9f;

   // values after reset or standby entry
   localparam logic [7:0] STATUS_RST  = 8'h00;
   localparam logic [7:0] IRQ_EN_RST  = 8'h9f;
   localparam logic [7:0] BLK_EN_RST  = 8'h00;

   // key bytes for word writes
   localparam logic [7:0] KEY_RD_LO = 8'h2d;
   localparam logic [7:0] KEY_RD_HI = 8'hd2;
   localparam logic [7:0] KEY_PE_LO = 8'h1e;
   localparam logic [7:0] KEY_PE_HI = 8'he1;

   // block count and block index width
   localparam int NUM_BLOCKS = 16;
   localparam int BLK_W      = 4;

endpackage

`default_nettype wire

//--- eag_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// sequencer and cpu side of the guard; mode levels stay as last set
module eag_far_side
(
   // clock
   input  wire logic        i_mclk,
   // sequencer and cpu lines into the guard
   output logic             o_cmd_valid,
   output logic             o_cmd_read,
   output logic             o_cmd_write,
   output logic             o_cmd_pe,
   output logic [3:0]       o_cmd_block,
   output logic             o_pe_normal_mode,
   output logic             o_data_pe_entry,
   output logic [6:0]       o_code_pe_entry,
   output logic             o_code_err,
   output logic             o_seq_error,
   output logic             o_seq_clear_done,
   output logic             o_fetch_valid,
   output logic             o_cpu_rd_valid,
   output logic [3:0]       o_cpu_rd_block
);
   // quiet at time zero
   initial
   begin
      {o_cmd_valid, o_cmd_read, o_cmd_write, o_cmd_pe} = 4'h0;
      {o_pe_normal_mode, o_data_pe_entry, o_code_err, o_seq_error} = 4'h0;
      {o_seq_clear_done, o_fetch_valid, o_cpu_rd_valid} = 3'h0;
      o_cmd_block = 4'h0;
      o_code_pe_entry = 7'h00;
      o_cpu_rd_block = 4'h0;
   end
   // one command; the block lines are scrambled after it so stale values never look valid
   task automatic cmd(input logic r, input logic w, input logic p, input logic [3:0] b,
                      input logic nm, input logic de, input logic [6:0] ce);
      @(posedge i_mclk);
      {o_cmd_read, o_cmd_write, o_cmd_pe, o_pe_normal_mode, o_data_pe_entry} <= {r, w, p, nm, de};
      o_code_pe_entry <= ce;
      o_cmd_block <= b;
      o_cmd_valid <= 1'b1;
      @(posedge i_mclk);
      o_cmd_valid <= 1'b0;
      o_cmd_block <= ~b;
   endtask
   // one-cycle event: 0 fetch, 1 cpu read, 2 code error, 3 sequencer fault, 4 clear done
   task automatic pulse(input int k, input logic [3:0] b);
      @(posedge i_mclk);
      {o_fetch_valid, o_cpu_rd_valid, o_code_err} <= {k == 0, k == 1, k == 2};
      {o_seq_error, o_seq_clear_done} <= {k == 3, k == 4};
      o_cpu_rd_block <= b;
      @(posedge i_mclk);
      {o_fetch_valid, o_cpu_rd_valid, o_code_err, o_seq_error, o_seq_clear_done} <= 5'h00;
      o_cpu_rd_block <= ~b;
   endtask
   // status-clear command, finishing after a chosen delay
   task automatic status_clear(input int dly);
      repeat (dly) @(posedge i_mclk);
      pulse(4, 4'h0);
   endtask
endmodule
`default_nettype wire

//--- test_eeprom_access_guard.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module test_eeprom_access_guard;
   // short names for the register map
   localparam logic [7:0] ST = eag_pkg::OFS_STATUS;
   localparam logic [7:0] IE = eag_pkg::OFS_IRQ_EN;
   localparam logic [7:0] RL = eag_pkg::OFS_RD_EN_LO;
   localparam logic [7:0] RH = eag_pkg::OFS_RD_EN_HI;
   localparam logic [7:0] PL = eag_pkg::OFS_PE_EN_LO;
   // clock, reset, mode pins and apb
   logic        i_mclk = 1'b0;
   logic        i_rst = 1'b1;
   logic        rom_dis = 1'b0;
   logic        standby = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, lock, ill, irq;
   logic [31:0] prdata, rdata;
   logic        rerr;
   logic        cv, cr, cw, cp, nm, de, cerr, serr, sclr, fv, rv;
   logic [3:0]  cb, rb;
   logic [6:0]  ce;
   logic [15:0] rd_en, pe_en;
   logic [7:0]  ex [8] = '{8'h14, 8'h11, 8'h18, 8'h18, 8'h18, 8'h90, 8'h10, 8'h00};
   int          n_fail = 0;
   int          cmp_count = 0;
   int          ill_n = 0;
   int          ib;

   eag_guard dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_pslverr(pslverr),
      .o_prdata(prdata), .i_rom_disabled(rom_dis), .i_hw_standby(standby), .i_cmd_valid(cv),
      .i_cmd_read(cr), .i_cmd_write(cw), .i_cmd_pe(cp), .i_cmd_block(cb), .i_pe_normal_mode(nm),
      .i_data_pe_entry(de), .i_code_pe_entry(ce), .i_code_flash_access_err(cerr), .i_seq_error(serr),
      .i_seq_clear_done(sclr), .i_fetch_valid(fv), .i_cpu_rd_valid(rv), .i_cpu_rd_block(rb),
      .o_cmd_lock(lock), .o_illegal_cmd_err(ill), .o_block_read_en(rd_en), .o_block_pe_en(pe_en),
      .o_flash_error_irq(irq));
   eag_far_side far (.i_mclk(i_mclk), .o_cmd_valid(cv), .o_cmd_read(cr), .o_cmd_write(cw), .o_cmd_pe(cp),
      .o_cmd_block(cb), .o_pe_normal_mode(nm), .o_data_pe_entry(de), .o_code_pe_entry(ce),
      .o_code_err(cerr), .o_seq_error(serr), .o_seq_clear_done(sclr), .o_fetch_valid(fv),
      .o_cpu_rd_valid(rv), .o_cpu_rd_block(rb));

   // 100 MHz clock
   always #5 i_mclk = ~i_mclk;
   // count cycles of the illegal-command pulse mid-cycle, away from the launching edge
   always @(negedge i_mclk)
      if (ill === 1'b1) ill_n++;

   // apb transfer: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      @(posedge i_mclk);
      {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, 16'h0000, d, s};
      @(posedge i_mclk);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a hung transfer
      do
      begin
         @(posedge i_mclk);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   // read a register and compare it
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 16'h0000, 4'h0);
      `CHK($sformatf("reg %h", a), e, rdata)
   endtask
   // full recovery: read, write 0x10, then the status-clear command
   task automatic clr;
      apb(1'b0, ST, 16'h0000, 4'h0);
      apb(1'b1, ST, 16'h0010, 4'h1);
      far.status_clear(0);
      repeat (2) @(posedge i_mclk);
   endtask
   task automatic fin(input string s);
      $display("test %s done", s);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog well past the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      n_fail++;
      summarize();
   end

   // test sequence
   initial
   begin
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_mclk);
      chk_rd(ST, 32'h00);
      chk_rd(IE, 32'h9f);
      chk_rd(RL, 32'h00);
      chk_rd(RH, 32'h00);
      `CHK("irq", 1'b0, irq)
      fin("reset");
      apb(1'b1, RL, 16'h2da5, 4'h3);
      apb(1'b1, RH, 16'h2d3c, 4'h3);
      apb(1'b1, RL, 16'h2dff, 4'h1);
      apb(1'b1, RH, 16'hd281, 4'h3);
      apb(1'b1, PL, 16'h1e01, 4'h3);
      apb(1'b1, eag_pkg::OFS_PE_EN_HI, 16'he1c0, 4'h3);
      apb(1'b1, IE, 16'h00ff, 4'h1);
      chk_rd(IE, 32'h9f);
      chk_rd(RL, 32'ha5);
      chk_rd(RH, 32'h81);
      `CHK("rd_en", 16'h81a5, rd_en)
      `CHK("pe_en", 16'hc001, pe_en)
      chk_rd(ST, 32'h00);
      apb(1'b0, 8'h20, 16'h0000, 4'h0);
      `CHK("slverr", 1'b1, rerr)
      `CHK("unmapped", 32'h0, rdata)
      fin("keys");
      far.pulse(1, 4'd0);
      far.pulse(1, 4'd8);
      chk_rd(ST, 32'h00);
      far.pulse(1, 4'd1);
      apb(1'b1, ST, 16'h0010, 4'h1);
      chk_rd(ST, 32'h12);
      #1;
      `CHK("lock", 1'b1, lock)
      `CHK("irq", 1'b1, irq)
      apb(1'b1, ST, 16'h00ff, 4'h1);
      chk_rd(ST, 32'h12);
      apb(1'b1, ST, 16'h0010, 4'h1);
      chk_rd(ST, 32'h10);
      far.status_clear(3);
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK("lock", 1'b0, lock)
      `CHK("irq", 1'b0, irq)
      chk_rd(ST, 32'h00);
      fin("clear");
      for (int k = 0; k < 8; k++)
      begin
         ib = ill_n;
         case (k)
            0: far.pulse(0, 4'd0);
            1: far.cmd(1'b0, 1'b0, 1'b1, 4'd1, 1'b1, 1'b1, 7'h00);
            2: far.cmd(1'b1, 1'b0, 1'b0, 4'd2, 1'b1, 1'b1, 7'h00);
            3: far.cmd(1'b0, 1'b1, 1'b0, 4'd2, 1'b1, 1'b0, 7'h00);
            4: far.cmd(1'b1, 1'b0, 1'b0, 4'd2, 1'b0, 1'b0, 7'h01);
            5: far.pulse(2, 4'd0);
            6: far.pulse(3, 4'd0);
            default: far.cmd(1'b0, 1'b0, 1'b1, 4'd0, 1'b1, 1'b1, 7'h00);
         endcase
         repeat (2) @(posedge i_mclk);
         chk_rd(ST, {24'h0, ex[k]});
         `CHK("illegal pulses", (k >= 2 && k <= 4) ? 1 : 0, ill_n - ib)
         clr();
      end
      fin("events");
      apb(1'b1, IE, 16'h0000, 4'h1);
      far.pulse(0, 4'd0);
      repeat (3) @(posedge i_mclk);
      #1;
      `CHK("irq", 1'b0, irq)
      apb(1'b1, IE, 16'h0004, 4'h1);
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK("irq", 1'b1, irq)
      fin("mask");
      @(posedge i_mclk);
      rom_dis <= 1'b1;
      repeat (4) @(posedge i_mclk);
      chk_rd(ST, 32'h00);
      chk_rd(RL, 32'h00);
      apb(1'b1, IE, 16'h009f, 4'h1);
      apb(1'b1, RL, 16'h2d00, 4'h3);
      rom_dis <= 1'b0;
      repeat (4) @(posedge i_mclk);
      chk_rd(IE, 32'h04);
      chk_rd(RL, 32'ha5);
      chk_rd(ST, 32'h14);
      fin("rom off");
      standby <= 1'b1;
      repeat (4) @(posedge i_mclk);
      standby <= 1'b0;
      repeat (4) @(posedge i_mclk);
      chk_rd(ST, 32'h00);
      chk_rd(IE, 32'h9f);
      `CHK("rd_en", 16'h0000, rd_en)
      `CHK("lock", 1'b0, lock)
      fin("standby");
      summarize();
   end
endmodule
`default_nettype wire
